// ===== inc/glp_pkg.sv
// Package of constants and state types shared by the bus port modules.
package glp_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_NS   = 50;   // System clock period at 20 MHz.
  localparam int unsigned SETUP_NS = 100;  // Data settle time before data-valid.
  localparam int unsigned SETUP_CYC_I = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0]  SETUP_CYC = SETUP_CYC_I[1:0];
  localparam logic [1:0]  CNT_ONE   = 2'h1;

  // ---------------------------------------------------------------------------
  // Bus widths and address fields
  // ---------------------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned GRP_HI = 6;     // Top bit of the command group field.
  localparam int unsigned GRP_LO = 5;     // Bottom bit of the command group field.
  localparam int unsigned SYNC_W = 20;    // Width of the synchronised pin vector.
  localparam logic [1:0]  GRP_LISTEN = 2'h1;
  localparam logic [1:0]  GRP_TALK   = 2'h2;
  localparam logic [1:0]  GRP_SECOND = 2'h3;
  localparam logic [6:0]  LISTEN_OR  = 7'h20;
  localparam logic [6:0]  TALK_OR    = 7'h40;
  localparam logic [6:0]  CMD_UNLISTEN = 7'h3f;
  localparam logic [6:0]  CMD_UNTALK   = 7'h5f;

  // ---------------------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_NRDY = 2'b01,
    ACC_RDY  = 2'b10,
    ACC_DONE = 2'b11
  } glp_acc_e;

  typedef enum logic [1:0] {
    SRC_IDLE  = 2'b00,
    SRC_SETUP = 2'b01,
    SRC_WAIT  = 2'b10,
    SRC_DAV   = 2'b11
  } glp_src_e;

endpackage

// ===== inc/glp_acc_if.sv
// Interface joining the port core to its acceptor handshake engine.
`timescale 1ns/1ns
interface glp_acc_if;
  import glp_pkg::*;
  logic              en;       // Take part in the handshake.
  logic              take_ok;  // Next byte may be taken.
  logic              dav;      // Data valid, true polarity, synchronised.
  logic              atn;      // Attention, true polarity, synchronised.
  logic              eoi;      // End marker, true polarity, synchronised.
  logic [DATA_W-1:0] data;     // Data lines, true polarity, synchronised.
  logic              nrfd;     // Assert not-ready-for-data.
  logic              ndac;     // Assert not-data-accepted.
  logic              stb;      // One-cycle pulse: byte captured.
  logic              byte_atn; // Captured byte was sent under attention.
  logic              byte_eoi; // Captured byte carried the end marker.
  logic [DATA_W-1:0] byte_q;   // Captured byte.

  modport ctl (output en, take_ok, dav, atn, eoi, data,
               input  nrfd, ndac, stb, byte_atn, byte_eoi, byte_q);
  modport eng (input  en, take_ok, dav, atn, eoi, data,
               output nrfd, ndac, stb, byte_atn, byte_eoi, byte_q);
endinterface

// ===== design/glp_acceptor.sv
// Acceptor handshake engine: drives not-ready and not-accepted, captures bytes.
`timescale 1ns/1ns
module glp_acceptor (
  input wire logic clk_sys,
  input wire logic rst_sync_b,
  glp_acc_if.eng   acc
);
  import glp_pkg::*;

  glp_acc_e state_q;

  // ---------------------------------------------------------------------------
  // Handshake sequence
  // ---------------------------------------------------------------------------
  // Both lines are released while not taking part, so an idle port never stalls the bus.
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_q      <= ACC_IDLE;
      acc.nrfd     <= 1'b0;
      acc.ndac     <= 1'b0;
      acc.stb      <= 1'b0;
      acc.byte_atn <= 1'b0;
      acc.byte_eoi <= 1'b0;
      acc.byte_q   <= '0;
    end else begin
      acc.stb <= 1'b0;
      if (!acc.en) begin
        state_q  <= ACC_IDLE;
        acc.nrfd <= 1'b0;
        acc.ndac <= 1'b0;
      end else begin
        case (state_q)
          ACC_IDLE: begin
            state_q  <= ACC_NRDY;
            acc.nrfd <= 1'b1;
            acc.ndac <= 1'b1;
          end
          ACC_NRDY: begin
            // Ready only once data-valid is gone and the consumer has room.
            if (!acc.dav && acc.take_ok) begin
              state_q  <= ACC_RDY;
              acc.nrfd <= 1'b0;
            end
          end
          ACC_RDY: begin
            // Capture and release not-accepted on the same edge, raising not-ready again.
            if (acc.dav) begin
              state_q      <= ACC_DONE;
              acc.nrfd     <= 1'b1;
              acc.ndac     <= 1'b0;
              acc.stb      <= 1'b1;
              acc.byte_q   <= acc.data;
              acc.byte_atn <= acc.atn;
              acc.byte_eoi <= acc.eoi;
            end
          end
          ACC_DONE: begin
            if (!acc.dav) begin
              state_q  <= ACC_NRDY;
              acc.ndac <= 1'b1;
            end
          end
          default: begin
            state_q <= ACC_IDLE;
          end
        endcase
      end
    end
  end

endmodule // glp_acceptor

// ===== design/glp_port.sv
// Device-side talker and listener port for the parallel instrument bus.
//
// Functional notes
// - Listener signals ready before any byte transfer begins.
// - Talker drives the byte, then asserts data valid.
// - Listener captures the byte on data valid, then signals accepted.
// - After acceptance the talker releases data valid and the data lines.
// - Listener re-signals ready only after data valid is withdrawn.
// - Eight data lines, five management lines, three handshake lines.
// - Primary address 0 to 31 comes from switches.
// - Primary address OR hex 20 is our listen address.
// - Primary address OR hex 40 is our talk address.
// - Secondary address codes hex 60 to 7F may follow a primary address.
// - Secondary addresses are ignored; primary address alone selects us.
// - When talking, response bytes go out one per handshake.
// - Unlisten removes us from the listen state.
// - All bus lines are low-true.
// - Bytes under attention are commands, otherwise data.
// - Not-accepted stays asserted until each acceptor has taken the byte.
`timescale 1ns/1ns
module glp_port (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  input  wire logic [glp_pkg::ADDR_W-1:0]    addr_sw,
  input  wire logic [glp_pkg::DATA_W-1:0]    dio_in,
  output logic      [glp_pkg::DATA_W-1:0]    dio_out,
  output logic      [glp_pkg::DATA_W-1:0]    dio_oe_b,
  input  wire logic                          atn_in,
  input  wire logic                          ifc_in,
  input  wire logic                          ren_in,
  input  wire logic                          eoi_in,
  output logic                               eoi_out,
  output logic                               eoi_oe_b,
  output logic                               srq_out,
  output logic                               srq_oe_b,
  input  wire logic                          dav_in,
  output logic                               dav_out,
  output logic                               dav_oe_b,
  input  wire logic                          nrfd_in,
  output logic                               nrfd_out,
  output logic                               nrfd_oe_b,
  input  wire logic                          ndac_in,
  output logic                               ndac_out,
  output logic                               ndac_oe_b,
  input  wire logic                          srq_req,
  output logic      [glp_pkg::DATA_W-1:0]    rx_data,
  output logic                               rx_valid,
  output logic                               rx_eoi,
  input  wire logic                          rx_ready,
  input  wire logic [glp_pkg::DATA_W-1:0]    tx_data,
  input  wire logic                          tx_last,
  input  wire logic                          tx_valid,
  output logic                               tx_taken,
  output logic                               listen,
  output logic                               talk,
  output logic                               remote
);
  import glp_pkg::*;
  logic [1:0]              rst_sync_q;
  logic                    rst_sync_b;
  logic [SYNC_W-1:0]       meta_q;
  logic [SYNC_W-1:0]       pin_q;
  logic [DATA_W-1:0]       data_t;
  logic                    atn_t;
  logic                    ifc_t;
  logic                    ren_t;
  logic                    eoi_t;
  logic                    dav_t;
  logic                    nrfd_t;
  logic                    ndac_t;
  logic [ADDR_W-1:0]       addr_q;
  logic                    listen_q;
  logic                    talk_q;
  logic                    talk_act;
  logic [6:0]              cmd7;
  glp_src_e                src_q;
  logic [1:0]              cnt_q;
  logic                    pend_q;
  logic [DATA_W-1:0]       tx_byte_q;
  logic                    tx_last_q;
  logic                    drive_q;
  logic                    dav_q;
  logic [DATA_W-1:0]       pull_q;
  glp_acc_if acc ();
  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  // Assertion is immediate; release is timed to the clock to avoid recovery hazards.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_sync_q[1];
  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Every bus pin and the address switches pass two flip-flops.
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      meta_q <= {SYNC_W{1'b1}};
      pin_q  <= {SYNC_W{1'b1}};
    end else begin
      meta_q <= {addr_sw, atn_in, ifc_in, ren_in, eoi_in, dav_in, nrfd_in, ndac_in, dio_in};
      pin_q  <= meta_q;
    end
  end
  // Lines are low-true, so the inverted level is the logical value.
  assign data_t = ~pin_q[DATA_W-1:0];
  assign ndac_t = ~pin_q[DATA_W];
  assign nrfd_t = ~pin_q[DATA_W+1];
  assign dav_t  = ~pin_q[DATA_W+2];
  assign eoi_t  = ~pin_q[DATA_W+3];
  assign ren_t  = ~pin_q[DATA_W+4];
  assign ifc_t  = ~pin_q[DATA_W+5];
  assign atn_t  = ~pin_q[DATA_W+6];
  // ---------------------------------------------------------------------------
  // Primary address
  // ---------------------------------------------------------------------------
  // The switch value is followed continuously; five bits cannot leave 0 to 31.
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      addr_q <= '0;
    end else begin
      addr_q <= pin_q[SYNC_W-1:DATA_W+7];
    end
  end
  // ---------------------------------------------------------------------------
  // Acceptor engine
  // ---------------------------------------------------------------------------
  // Every device must take part under attention; data is taken only when listening.
  assign acc.en      = atn_t || (listen_q && !talk_act);
  assign acc.take_ok = atn_t || rx_ready;
  assign acc.dav     = dav_t;
  assign acc.atn     = atn_t;
  assign acc.eoi     = eoi_t;
  assign acc.data    = data_t;
  glp_acceptor u_acceptor (
    .clk_sys    (clk_sys),
    .rst_sync_b (rst_sync_b),
    .acc        (acc.eng)
  );
  // ---------------------------------------------------------------------------
  // Address and command decode
  // ---------------------------------------------------------------------------
  // Bit 8 of a command byte carries no meaning and is ignored.
  assign cmd7 = acc.byte_q[6:0];
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      listen_q <= 1'b0;
      talk_q   <= 1'b0;
    end else if (ifc_t) begin
      listen_q <= 1'b0;
      talk_q   <= 1'b0;
    end else if (acc.stb && acc.byte_atn) begin
      if (cmd7 == (LISTEN_OR | {2'h0, addr_q})) begin
        listen_q <= 1'b1;
      end
      if (cmd7 == CMD_UNLISTEN) begin
        listen_q <= 1'b0;
      end
      if (cmd7 == (TALK_OR | {2'h0, addr_q})) begin
        talk_q <= 1'b1;
      end else if (cmd7[GRP_HI:GRP_LO] == GRP_TALK) begin
        // Untalk and any other talker's address both end our turn.
        talk_q <= 1'b0;
      end
      // Secondary codes fall in their own group and change nothing here.
    end
  end
  // ---------------------------------------------------------------------------
  // Received data to the user
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rx_valid <= 1'b0;
      rx_data  <= '0;
      rx_eoi   <= 1'b0;
    end else begin
      rx_valid <= acc.stb && !acc.byte_atn && listen_q;
      if (acc.stb && !acc.byte_atn && listen_q) begin
        rx_data <= acc.byte_q;
        rx_eoi  <= acc.byte_eoi;
      end
    end
  end
  // ---------------------------------------------------------------------------
  // Source handshake
  // ---------------------------------------------------------------------------
  // Attention or loss of the talk role drops the lines at once; a held byte is kept, except under interface clear.
  assign talk_act = talk_q && !atn_t && !ifc_t;
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      src_q     <= SRC_IDLE;
      cnt_q     <= '0;
      pend_q    <= 1'b0;
      tx_byte_q <= '0;
      tx_last_q <= 1'b0;
      tx_taken  <= 1'b0;
      drive_q   <= 1'b0;
      dav_q     <= 1'b0;
    end else begin
      tx_taken <= 1'b0;
      if (!talk_act) begin
        src_q   <= SRC_IDLE;
        drive_q <= 1'b0;
        dav_q   <= 1'b0;
        pend_q  <= pend_q && !ifc_t;
      end else begin
        case (src_q)
          SRC_IDLE: begin
            // One response byte per handshake.
            if (pend_q || tx_valid) begin
              if (!pend_q) begin
                tx_byte_q <= tx_data;
                tx_last_q <= tx_last;
                tx_taken  <= 1'b1;
                pend_q    <= 1'b1;
              end
              drive_q <= 1'b1;
              cnt_q   <= SETUP_CYC;
              src_q   <= SRC_SETUP;
            end
          end
          SRC_SETUP: begin
            // Data lines settle before data-valid is raised.
            if (cnt_q == CNT_ONE) begin
              src_q <= SRC_WAIT;
            end
            cnt_q <= cnt_q - CNT_ONE;
          end
          SRC_WAIT: begin
            // All listeners ready and the previous byte's accepted line back low.
            if (!nrfd_t && ndac_t) begin
              dav_q <= 1'b1;
              src_q <= SRC_DAV;
            end
          end
          SRC_DAV: begin
            // Accepted is seen only when the slowest listener lets go.
            if (!ndac_t) begin
              dav_q   <= 1'b0;
              drive_q <= 1'b0;
              pend_q  <= 1'b0;
              src_q   <= SRC_IDLE;
            end
          end
          default: begin
            src_q <= SRC_IDLE;
          end
        endcase
      end
    end
  end
  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  // Lines are open-drain: a true bit pulls low, a false bit releases.
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pull_q    <= '0;
      dio_oe_b  <= {DATA_W{1'b1}};
      dav_oe_b  <= 1'b1;
      eoi_oe_b  <= 1'b1;
      nrfd_oe_b <= 1'b1;
      ndac_oe_b <= 1'b1;
      srq_oe_b  <= 1'b1;
      listen    <= 1'b0;
      talk      <= 1'b0;
      remote    <= 1'b0;
    end else begin
      pull_q    <= '0;
      dio_oe_b  <= ~(tx_byte_q & {DATA_W{drive_q}});
      dav_oe_b  <= ~dav_q;
      eoi_oe_b  <= ~(drive_q && tx_last_q);
      nrfd_oe_b <= ~acc.nrfd;
      ndac_oe_b <= ~acc.ndac;
      srq_oe_b  <= ~srq_req;
      listen    <= listen_q;
      talk      <= talk_q;
      remote    <= ren_t;
    end
  end
  assign dio_out  = pull_q;
  assign dav_out  = pull_q[0];
  assign eoi_out  = pull_q[0];
  assign nrfd_out = pull_q[0];
  assign ndac_out = pull_q[0];
  assign srq_out  = pull_q[0];
endmodule // glp_port

// ===== tb/glp_ctrl_model.sv
// Behavioural bus controller that sources commands and data and accepts talker bytes.
`timescale 1ns/1ns
module glp_ctrl_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] dio_line,
  input  wire logic       dav_line,
  input  wire logic       nrfd_line,
  input  wire logic       ndac_line,
  input  wire logic       eoi_line,
  output logic      [7:0] m_dio,
  output logic            m_dav,
  output logic            m_nrfd,
  output logic            m_ndac,
  output logic            m_atn
);
  // ----------------------------------------
  // Source and acceptor handshakes
  // ----------------------------------------
  // Drives are true-high here; the bench turns them into low-true levels.
  // This is the sole controller and it addresses one talker at a time.
  initial {m_dio, m_dav, m_nrfd, m_ndac, m_atn} = '0;

  // Sends one byte; acceptor lines are let go before ATN moves, so they stay put afterwards.
  task automatic src(input logic [7:0] b, input logic a);
    int n;
    m_nrfd <= 1'b0;
    m_ndac <= 1'b0;
    @(negedge clk_sys);
    m_atn <= a;
    m_dio <= b;
    repeat (3) @(negedge clk_sys);
    for (n = 0; n < 400 && !(nrfd_line && !ndac_line); n++) @(negedge clk_sys);
    m_dav <= 1'b1;
    for (n = 0; n < 400 && !ndac_line; n++) @(negedge clk_sys);
    m_dav <= 1'b0;
    m_dio <= 8'h00;
    @(negedge clk_sys);
  endtask

  // Accepts one byte; the talker is never let past a line it should wait for.
  task automatic acc(output logic [7:0] b, output logic e);
    int n;
    m_ndac <= 1'b1;
    m_nrfd <= 1'b1;
    @(negedge clk_sys);
    m_nrfd <= 1'b0;
    for (n = 0; n < 400 && dav_line; n++) @(negedge clk_sys);
    b = ~dio_line;
    e = ~eoi_line;
    m_nrfd <= 1'b1;
    @(negedge clk_sys);
    m_ndac <= 1'b0;
    for (n = 0; n < 400 && !dav_line; n++) @(negedge clk_sys);
    m_ndac <= 1'b1;
    @(negedge clk_sys);
  endtask

  task automatic set_atn(input logic a);
    m_atn <= a;
  endtask
endmodule // glp_ctrl_model

// ===== tb/glp_port_chk.sv
// Concurrent checks on the handshake pins of the talker and listener port.
`timescale 1ns/1ns
module glp_port_chk
  import glp_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic [7:0]  dio_in,
  input wire logic [7:0]  dio_oe_b,
  input wire logic        atn_in,
  input wire logic        dav_in,
  input wire logic        dav_oe_b,
  input wire logic        nrfd_in,
  input wire logic        nrfd_oe_b,
  input wire logic        ndac_in,
  input wire logic        ndac_oe_b,
  input wire logic        eoi_oe_b,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        talk
);
  // ----------------------------------------
  // Handshake relations
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_dav_ready; $fell(dav_oe_b) |-> $past(nrfd_in, 2) && !$past(ndac_in, 2); endproperty
  a_dav_ready: assert property (p_dav_ready) else $error("data valid before ready");
  property p_settle; $fell(dav_oe_b) |-> $stable(dio_oe_b) && $past(dio_oe_b, 2) == dio_oe_b; endproperty
  a_settle: assert property (p_settle) else $error("data not settled before valid");
  property p_hold; !dav_oe_b && !$past(dav_oe_b) |-> $stable(dio_oe_b) && $stable(eoi_oe_b); endproperty
  a_hold: assert property (p_hold) else $error("data moved while valid");
  property p_release; $rose(dav_oe_b) |-> dio_oe_b == 8'hff && eoi_oe_b; endproperty
  a_release: assert property (p_release) else $error("data kept after valid dropped");
  property p_accept; $rose(ndac_oe_b) && !nrfd_oe_b |-> !$past(dav_in, 2); endproperty
  a_accept: assert property (p_accept) else $error("accepted without valid");
  property p_ready; $rose(nrfd_oe_b) && !ndac_oe_b |-> $past(dav_in) && $past(dav_in, 2); endproperty
  a_ready: assert property (p_ready) else $error("ready while valid still shown");
  property p_ndac; $fell(dav_in) && !ndac_oe_b |-> !ndac_oe_b [*3]; endproperty
  a_ndac: assert property (p_ndac) else $error("not accepted dropped too soon");
  property p_rx; rx_valid |-> !nrfd_oe_b && ndac_oe_b && rx_data == ~$past(dio_in, 2); endproperty
  a_rx: assert property (p_rx) else $error("received byte wrong");
  property p_atn; $fell(atn_in) |-> ##[1:4] (dav_oe_b && dio_oe_b == 8'hff); endproperty
  a_atn: assert property (p_atn) else $error("talker kept lines under attention");
  property p_quiet; !talk && !$past(talk) |-> dio_oe_b == 8'hff && dav_oe_b; endproperty
  a_quiet: assert property (p_quiet) else $error("lines driven while not talking");
endmodule // glp_port_chk

bind glp_port glp_port_chk chk_i (
  .clk_sys(clk_sys), .rst_b(rst_b), .dio_in(dio_in), .dio_oe_b(dio_oe_b), .atn_in(atn_in),
  .dav_in(dav_in), .dav_oe_b(dav_oe_b), .nrfd_in(nrfd_in), .nrfd_oe_b(nrfd_oe_b), .ndac_in(ndac_in),
  .ndac_oe_b(ndac_oe_b), .eoi_oe_b(eoi_oe_b), .rx_valid(rx_valid), .rx_data(rx_data), .talk(talk)
);

// ===== tb/testbench.sv
// Self-checking bench for the talker and listener port against a controller model.
`timescale 1ns/1ns
module testbench;
  import glp_pkg::*;
  // ----------------------------------------
  // Signals, lines and instances
  // ----------------------------------------
  logic       clk_sys, rst_b, srq_req, rx_ready, tx_last, tx_valid, ge;
  logic [4:0] addr_sw, pa;
  logic [7:0] tx_data, dio_out, dio_oe_b, rx_data, m_dio, dio_l, b, gb;
  logic       eoi_out, eoi_oe_b, srq_out, srq_oe_b, dav_out, dav_oe_b, nrfd_out, nrfd_oe_b, ndac_out, ndac_oe_b;
  logic       rx_valid, rx_eoi, tx_taken, listen, talk, remote, m_dav, m_nrfd, m_ndac, m_atn;
  logic       dav_l, nrfd_l, ndac_l;
  logic [7:0] expq[$], rxq[$];
  logic [31:0] seed;
  int         failures, checks_done, cycles, k, i;

  // Open-drain lines with pull-ups: whoever pulls low wins.
  assign dio_l  = dio_oe_b & ~m_dio;
  assign dav_l  = dav_oe_b & ~m_dav;
  assign nrfd_l = nrfd_oe_b & ~m_nrfd;
  assign ndac_l = ndac_oe_b & ~m_ndac;

  glp_port uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .addr_sw(addr_sw), .dio_in(dio_l), .dio_out(dio_out), .dio_oe_b(dio_oe_b),
    .atn_in(~m_atn), .ifc_in(1'b1), .ren_in(1'b1), .eoi_in(eoi_oe_b), .eoi_out(eoi_out), .eoi_oe_b(eoi_oe_b),
    .srq_out(srq_out), .srq_oe_b(srq_oe_b), .dav_in(dav_l), .dav_out(dav_out), .dav_oe_b(dav_oe_b),
    .nrfd_in(nrfd_l), .nrfd_out(nrfd_out), .nrfd_oe_b(nrfd_oe_b), .ndac_in(ndac_l), .ndac_out(ndac_out),
    .ndac_oe_b(ndac_oe_b), .srq_req(srq_req), .rx_data(rx_data), .rx_valid(rx_valid), .rx_eoi(rx_eoi),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid), .tx_taken(tx_taken),
    .listen(listen), .talk(talk), .remote(remote)
  );
  glp_ctrl_model ctl (
    .clk_sys(clk_sys), .dio_line(dio_l), .dav_line(dav_l), .nrfd_line(nrfd_l), .ndac_line(ndac_l),
    .eoi_line(eoi_oe_b), .m_dio(m_dio), .m_dav(m_dav), .m_nrfd(m_nrfd), .m_ndac(m_ndac), .m_atn(m_atn)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] rnd();
    repeat (8) seed = lfsr(seed);
    return seed[7:0];
  endfunction
  // Address byte as the controller sends it: primary address merged into a group code.
  function automatic logic [7:0] addr_cmd(input logic [4:0] p, input logic [6:0] grp);
    return {1'b0, grp | {2'b00, p}};
  endfunction
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // Offers one response byte and drops the request once it was taken.
  task automatic put_tx(input logic [7:0] v, input logic l);
    int n;
    tx_data = v;
    tx_last = l;
    tx_valid = 1'b1;
    for (n = 0; n < 100 && tx_taken !== 1'b1; n++) @(negedge clk_sys);
    tx_valid = 1'b0;
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, monitor, timeout and main sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Received data bytes are queued for comparison in order.
  always @(posedge clk_sys) if (rx_valid === 1'b1) rxq.push_back(rx_data);
  // The run needs under a thousand cycles; far more means a stuck handshake.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      results();
    end
  end

  initial begin
    {rst_b, srq_req, tx_last, tx_valid, tx_data, addr_sw} = '0;
    rx_ready = 1'b1;
    seed = 32'h529b695d;
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(dio_oe_b === 8'hff && dav_oe_b === 1'b1 && nrfd_oe_b === 1'b1 && ndac_oe_b === 1'b1, "reset drive");
    chk(listen === 1'b0 && talk === 1'b0 && remote === 1'b0 && srq_oe_b === 1'b1, "reset state");
    srq_req = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(srq_oe_b === 1'b0, "service request line");
    srq_req = 1'b0;
    $display("test reset done");
    for (k = 0; k < 3; k++) begin
      b = rnd();
      pa = (k == 0) ? 5'h00 : (k == 1) ? 5'h1e : ((b[4:0] == 5'h1f) ? 5'h1e : b[4:0]);
      addr_sw = pa;
      repeat (6) @(negedge clk_sys);
      ctl.src(addr_cmd(pa ^ 5'h01, LISTEN_OR), 1'b1);
      chk(listen === 1'b0, "foreign listen address");
      ctl.src(addr_cmd(pa, LISTEN_OR), 1'b1);
      b = rnd();
      ctl.src({3'b011, b[4:0]}, 1'b1);
      repeat (2) @(negedge clk_sys);
      chk(listen === 1'b1, "own listen address");
      rxq.delete();
      expq.delete();
      for (i = 0; i < 6; i++) begin
        b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd();
        expq.push_back(b);
        if (i == 4) rx_ready = 1'b0;
        fork
          ctl.src(b, 1'b0);
          if (i == 4) begin
            repeat (20) @(negedge clk_sys);
            chk(nrfd_oe_b === 1'b0 && rxq.size() == 4, "stall while user busy");
            rx_ready = 1'b1;
          end
        join
      end
      repeat (8) @(negedge clk_sys);
      chk(rxq.size() == 6, "received count");
      foreach (expq[j]) chk(rxq[j] === expq[j], "received byte");
      ctl.src({1'b0, CMD_UNLISTEN}, 1'b1);
      repeat (2) @(negedge clk_sys);
      chk(listen === 1'b0, "unlisten");
      ctl.src(addr_cmd(pa, TALK_OR), 1'b1);
      repeat (2) @(negedge clk_sys);
      chk(talk === 1'b1, "own talk address");
      ctl.set_atn(1'b0);
      @(negedge clk_sys);
      for (i = 0; i < 4; i++) begin
        b = rnd();
        fork
          put_tx(b, i == 3);
          ctl.acc(gb, ge);
        join
        chk(gb === b, "sent byte");
        chk(ge === (i == 3), "end marker");
      end
      ctl.src(k[0] ? addr_cmd(pa ^ 5'h02, TALK_OR) : {1'b0, CMD_UNTALK}, 1'b1);
      repeat (2) @(negedge clk_sys);
      chk(talk === 1'b0, "talk ended");
      $display("test %0d done", k);
    end
    results();
  end
endmodule // testbench
